// file: shared/atc_map.svh
// register indices, byte addresses, field positions, reset values and timing counts
`ifndef ATC_MAP_SVH
`define ATC_MAP_SVH

`define ATC_IDX_I_GAIN          6'h03
`define ATC_IDX_EXT_CFG         6'h09
`define ATC_IDX_Q_OFFSET        6'h0a
`define ATC_IDX_STATUS          6'h10
`define ATC_IDX_CAL_CMD         6'h11

`define ATC_ADDR_I_GAIN         {`ATC_IDX_I_GAIN, 2'b00}
`define ATC_ADDR_EXT_CFG        {`ATC_IDX_EXT_CFG, 2'b00}
`define ATC_ADDR_Q_OFFSET       {`ATC_IDX_Q_OFFSET, 2'b00}
`define ATC_ADDR_STATUS         {`ATC_IDX_STATUS, 2'b00}
`define ATC_ADDR_CAL_CMD        {`ATC_IDX_CAL_CMD, 2'b00}

`define ATC_RST_I_GAIN          16'h807f
`define ATC_RST_EXT_CFG         16'h03ff
`define ATC_RST_Q_OFFSET        16'h007f

`define ATC_GAIN_MSB            15
`define ATC_GAIN_LSB            7
`define ATC_GAIN_MID            9'h100
`define ATC_GAIN_REC_LOW        9'h0c0
`define ATC_GAIN_REC_HIGH       9'h1c0
`define ATC_EXT_PATTERN_BIT     15
`define ATC_EXT_TRIM_SKIP_BIT   14
`define ATC_OFS_MSB             15
`define ATC_OFS_LSB             8
`define ATC_OFS_SIGN_BIT        7

`define ATC_FILL_MASK_I_GAIN    16'h007f
`define ATC_FILL_VAL_I_GAIN     16'h007f
`define ATC_FILL_MASK_EXT_CFG   16'h3fff
`define ATC_FILL_VAL_EXT_CFG    16'h03ff
`define ATC_FILL_MASK_Q_OFFSET  16'h007f
`define ATC_FILL_VAL_Q_OFFSET   16'h007f

`define ATC_FS_MIN_MV           10'd560
`define ATC_FS_SPAN_MV          19'd280
`define ATC_GAIN_FULL_CODE      19'd511
`define ATC_OFS_FULL_UV         24'd45000
`define ATC_OFS_FULL_CODE       24'd255

`define ATC_TERM_TRIM_CYCLES    16'd64
`define ATC_CONV_CAL_CYCLES     16'd256

`endif

// file: shared/atc_pkg.sv
// types shared by the configuration register block and its helpers
package atc_pkg;

    typedef enum logic [1:0] {
        ATC_MODE_SDR   = 2'b00,
        ATC_MODE_DDR   = 2'b01,
        ATC_MODE_NODMX = 2'b10
    } atc_out_mode_e;

    typedef enum logic [3:0] {
        ATC_CAL_IDLE = 4'b0001,
        ATC_CAL_TRIM = 4'b0010,
        ATC_CAL_CONV = 4'b0100,
        ATC_CAL_DONE = 4'b1000
    } atc_cal_state_e;

    typedef struct packed {
        logic       over_range;
        logic [7:0] i_data;
        logic [7:0] q_data;
    } atc_word_s;

    typedef struct packed {
        logic       busy;
        logic       term_trim_active;
        logic       conv_cal_active;
        logic       data_clock_en;
    } atc_cal_status_s;

endpackage

// file: sim/adc_trim_ext_config_regs_bench.sv
// self-checking bench for the trim and extended configuration registers
`timescale 1ns/100ps
`include "atc_map.svh"
`define BCHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module adc_trim_ext_config_regs_bench
    import atc_pkg::*;
;
    logic                mclk, rst, psel, pen, pwr, pready, perr, cal_req, strobe;
    logic                neg, tps, skip, busy, trim_act, conv_act, clk_en, er, n;
    logic [7:0]          paddr, mag, m;
    logic [31:0]         pwdata, prdata, rd;
    logic [8:0]          gcode, c;
    logic [9:0]          fs_mv;
    logic signed [16:0]  uv;
    logic [2:0]          seen;
    atc_out_mode_e       mode;
    atc_word_s           conv, out_word, w;
    int                  fails, total_checks, cyc;
    logic [8:0]          gc [3] = '{9'h000, 9'h100, 9'h1ff};
    logic [7:0]          mc [3] = '{8'h00, 8'hff, 8'hff};

    atc_host_model u_host (.i_mclk(mclk), .i_pready(pready), .i_prdata(prdata), .i_pslverr(perr),
        .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata));

    atc_config_regs DUT (.i_mclk(mclk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr),
        .i_cal_request(cal_req), .i_output_mode(mode), .i_conv_word(conv), .i_word_strobe(strobe),
        .o_out_word(out_word), .o_i_gain_code(gcode), .o_i_full_scale_mv(fs_mv), .o_q_offset_mag(mag),
        .o_q_offset_neg(neg), .o_q_offset_uv(uv), .o_test_pattern_select(tps), .o_termination_trim_skip(skip),
        .o_cal_busy(busy), .o_term_trim_active(trim_act), .o_conv_cal_active(conv_act),
        .o_output_data_clock_en(clk_en));

    function automatic logic [9:0] exp_mv(input logic [8:0] g);
        return 10'(560 + int'(g) * 280 / 511);
    endfunction

    function automatic logic signed [16:0] exp_uv(input logic [7:0] mm, input logic nn);
        int v;
        v = int'(mm) * 45000 / 255;
        return 17'(nn ? -v : v);
    endfunction

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rd, er);
        repeat (2) @(negedge mclk);
        `BCHK("write error", 1'b0, er)
    endtask

    task automatic send_word(output atc_word_s ww);
        ww = atc_word_s'($urandom);
        @(posedge mclk);
        conv   <= ww;
        strobe <= 1'b1;
        @(posedge mclk);
        strobe <= 1'b0;
        @(negedge mclk);
    endtask

    // bounded waits so a stuck sequencer cannot hang the run
    task automatic run_cal(output logic [2:0] sn);
        int k;
        sn = 3'b000;
        k = 0;
        while (busy !== 1'b1 && k < 20)
        begin
            @(negedge mclk);
            k++;
        end
        while (busy === 1'b1 && k < 600)
        begin
            sn |= {trim_act === 1'b1, conv_act === 1'b1, clk_en !== 1'b1};
            @(negedge mclk);
            k++;
        end
        `BCHK("calibration end", 1'b0, busy)
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            complete_run();
        end
    end

    initial
    begin
        {rst, cal_req, strobe, conv} = {1'b1, 19'h0};
        mode = ATC_MODE_SDR;
        void'($urandom(32'hc272));
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        `BCHK("gain code", 9'h100, gcode)
        `BCHK("full scale", 10'd700, fs_mv)
        `BCHK("offset", 26'h0, {mag, neg, uv})
        `BCHK("ext bits", 2'b00, {tps, skip})
        u_host.xfer(1'b0, `ATC_ADDR_I_GAIN, 32'h0, rd, er);
        `BCHK("gain readback", 33'h0, {er, rd})
        u_host.xfer(1'b0, 8'h80, 32'h0, rd, er);
        `BCHK("unmapped error", 1'b1, er)
        $display("test reset done");
        for (int k = 0; k < 7; k++)
        begin
            // random codes stay inside the recommended band
            c = (k < 3) ? gc[k] : 9'(`ATC_GAIN_REC_LOW + $urandom_range(256));
            wr(`ATC_ADDR_I_GAIN, u_host.gain_word(c));
            `BCHK("gain code", c, gcode)
            `BCHK("full scale", exp_mv(c), fs_mv)
            `BCHK("busy after gain", 1'b0, busy)
        end
        $display("test gain done");
        for (int k = 0; k < 5; k++)
        begin
            m = (k < 3) ? mc[k] : 8'($urandom);
            n = (k < 3) ? (k == 2) : 1'($urandom);
            wr(`ATC_ADDR_Q_OFFSET, u_host.ofs_word(m, n));
            `BCHK("offset fields", {m, n}, {mag, neg})
            `BCHK("offset uv", exp_uv(m, n), uv)
            `BCHK("gain held", c, gcode)
        end
        $display("test offset done");
        for (int md = 0; md < 3; md++)
        begin
            @(posedge mclk);
            mode <= atc_out_mode_e'(md);
            wr(`ATC_ADDR_EXT_CFG, u_host.ext_word(1'b1, 1'b0));
            `BCHK("pattern select", 1'b1, tps)
            for (int j = 0; j < 4; j++)
            begin
                send_word(w);
                `BCHK("pattern word", {j[0], 8'(j), ~8'(j)}, out_word)
            end
        end
        wr(`ATC_ADDR_EXT_CFG, u_host.ext_word(1'b0, 1'b1));
        `BCHK("ext bits", 2'b01, {tps, skip})
        repeat (3)
        begin
            send_word(w);
            `BCHK("converter word", w, out_word)
        end
        $display("test pattern done");
        wr(`ATC_ADDR_CAL_CMD, 32'h1);
        run_cal(seen);
        `BCHK("skip calibration", 3'b010, seen)
        u_host.xfer(1'b0, `ATC_ADDR_STATUS, 32'h0, rd, er);
        `BCHK("status", 33'h100, {er, rd})
        wr(`ATC_ADDR_EXT_CFG, u_host.ext_word(1'b0, 1'b0));
        @(posedge mclk);
        cal_req <= 1'b1;
        run_cal(seen);
        @(posedge mclk);
        cal_req <= 1'b0;
        `BCHK("full calibration", 3'b111, seen)
        $display("test calibration done");
        complete_run();
    end
endmodule

// file: sim/atc_config_regs_monitor.sv
// port-level assertions for the configuration register block
`timescale 1ns/100ps
`include "atc_map.svh"
module atc_config_regs_monitor
    import atc_pkg::*;
(
    input wire logic               i_mclk,
    input wire logic               i_reset,
    input wire logic               i_psel,
    input wire logic               i_penable,
    input wire logic               i_pwrite,
    input wire logic [7:0]         i_paddr,
    input wire logic [31:0]        i_pwdata,
    input wire logic               i_word_strobe,
    input wire atc_word_s          i_conv_word,
    input wire atc_word_s          o_out_word,
    input wire logic [8:0]         o_i_gain_code,
    input wire logic [9:0]         o_i_full_scale_mv,
    input wire logic [7:0]         o_q_offset_mag,
    input wire logic               o_q_offset_neg,
    input wire logic signed [16:0] o_q_offset_uv,
    input wire logic               o_test_pattern_select,
    input wire logic               o_termination_trim_skip,
    input wire logic               o_cal_busy,
    input wire logic               o_term_trim_active,
    input wire logic               o_conv_cal_active,
    input wire logic               o_output_data_clock_en
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    sequence s_wr(a);
        i_psel && i_penable && i_pwrite && i_paddr == a;
    endsequence

    property p_rst;
        $fell(i_reset) |-> o_i_gain_code == `ATC_GAIN_MID && o_i_full_scale_mv == 10'd700 && o_q_offset_mag == 8'h00
            && !o_q_offset_neg && o_q_offset_uv == 17'sh0 && !o_test_pattern_select && !o_termination_trim_skip;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    property p_gain_wr;
        s_wr(`ATC_ADDR_I_GAIN) |=> o_i_gain_code == $past(i_pwdata[15:7]);
    endproperty
    a_gain_wr: assert property (p_gain_wr) else $error("gain write lost");
    property p_gain_mv;
        $stable(o_i_gain_code) [*2] |-> int'(o_i_full_scale_mv) == 560 + int'(o_i_gain_code) * 280 / 511;
    endproperty
    a_gain_mv: assert property (p_gain_mv) else $error("full scale map wrong");
    property p_ofs_wr;
        s_wr(`ATC_ADDR_Q_OFFSET) |=> o_q_offset_mag == $past(i_pwdata[15:8]) && o_q_offset_neg == $past(i_pwdata[7]);
    endproperty
    a_ofs_wr: assert property (p_ofs_wr) else $error("offset write lost");
    property p_ofs_uv;
        $stable({o_q_offset_mag, o_q_offset_neg}) [*2]
            |-> int'(o_q_offset_uv) == (o_q_offset_neg ? -1 : 1) * (int'(o_q_offset_mag) * 45000 / 255);
    endproperty
    a_ofs_uv: assert property (p_ofs_uv) else $error("offset map wrong");
    property p_ext_wr;
        s_wr(`ATC_ADDR_EXT_CFG) |=> o_test_pattern_select == $past(i_pwdata[15])
            && o_termination_trim_skip == $past(i_pwdata[14]);
    endproperty
    a_ext_wr: assert property (p_ext_wr) else $error("ext write lost");
    property p_hold;
        !(i_psel && i_penable && i_pwrite) |=> $stable({o_i_gain_code, o_q_offset_mag, o_q_offset_neg,
            o_test_pattern_select, o_termination_trim_skip});
    endproperty
    a_hold: assert property (p_hold) else $error("setting changed without write");
    property p_skip;
        $rose(o_cal_busy) && o_termination_trim_skip |-> (!o_term_trim_active && o_output_data_clock_en) [*8];
    endproperty
    a_skip: assert property (p_skip) else $error("trim ran or clock stopped");
    property p_conv;
        $rose(o_cal_busy) |-> ##[0:80] o_conv_cal_active;
    endproperty
    a_conv: assert property (p_conv) else $error("no converter calibration");
    property p_pass;
        !o_test_pattern_select && i_word_strobe |=> o_out_word == $past(i_conv_word);
    endproperty
    a_pass: assert property (p_pass) else $error("converter word not passed");
    property p_pat;
        o_test_pattern_select && i_word_strobe |=> o_out_word.q_data == ~o_out_word.i_data
            && o_out_word.over_range == o_out_word.i_data[0];
    endproperty
    a_pat: assert property (p_pat) else $error("pattern word wrong");
endmodule

bind atc_config_regs atc_config_regs_monitor u_mon (.*);

// file: sim/atc_host_model.sv
// apb host model issuing configuration writes and reads
`timescale 1ns/100ps
module atc_host_model
(
    input  wire logic        i_mclk,
    input  wire logic        i_pready,
    input  wire logic [31:0] i_prdata,
    input  wire logic        i_pslverr,
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic      [7:0]  o_paddr,
    output logic      [31:0] o_pwdata
);
    initial
    begin
        {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} = '0;
    end

    // filler bits always go out at their fixed levels
    function automatic logic [31:0] gain_word(input logic [8:0] c);
        return {16'h0000, c, 7'h7f};
    endfunction

    function automatic logic [31:0] ext_word(input logic tp, input logic sk);
        return {16'h0000, tp, sk, 4'h0, 10'h3ff};
    endfunction

    function automatic logic [31:0] ofs_word(input logic [7:0] m, input logic n);
        return {16'h0000, m, n, 7'h7f};
    endfunction

    // waits on pready without assuming any latency
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge i_mclk);
        o_psel    <= 1'b1;
        o_pwrite  <= wr;
        o_paddr   <= a;
        o_pwdata  <= d;
        @(posedge i_mclk);
        o_penable <= 1'b1;
        do @(posedge i_mclk); while (i_pready !== 1'b1);
        q = i_prdata;
        err = i_pslverr;
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
        // released lines must not keep showing the last value
        o_paddr   <= ~a;
        o_pwdata  <= ~d;
    endtask
endmodule

// file: verilog/atc_cal_seq.sv
// calibration sequencer: optional termination trim, then converter calibration
`timescale 1ns/100ps
`include "atc_map.svh"
module atc_cal_seq
    import atc_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_reset,
    input  wire logic       i_start,
    input  wire logic       i_trim_skip,
    output atc_cal_status_s o_status
);
    atc_cal_state_e state;
    atc_cal_state_e next_state;
    logic [15:0]    count;
    logic           skip_latched;

    always_comb
    begin
        next_state = state;
        case (state)
            ATC_CAL_IDLE: if (i_start) next_state = skip_latched_next() ? ATC_CAL_CONV : ATC_CAL_TRIM;
            ATC_CAL_TRIM: if (count == `ATC_TERM_TRIM_CYCLES - 16'd1) next_state = ATC_CAL_CONV;
            ATC_CAL_CONV: if (count == `ATC_CONV_CAL_CYCLES - 16'd1) next_state = ATC_CAL_DONE;
            ATC_CAL_DONE: next_state = ATC_CAL_IDLE;
            default:      next_state = ATC_CAL_IDLE;
        endcase
    end

    function automatic logic skip_latched_next();
        return i_trim_skip;
    endfunction

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            state <= ATC_CAL_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset || next_state != state)
        begin
            count <= 16'h0000;
        end
        else
        begin
            count <= count + 16'h0001;
        end
    end

    // skip setting is frozen for the whole cycle so a mid-cycle write cannot glitch the clock
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            skip_latched <= 1'b0;
        end
        else if (state == ATC_CAL_IDLE && i_start)
        begin
            skip_latched <= i_trim_skip;
        end
    end

    always_comb
    begin
        o_status.busy             = (state != ATC_CAL_IDLE);
        o_status.term_trim_active = (state == ATC_CAL_TRIM);
        o_status.conv_cal_active  = (state == ATC_CAL_CONV);
        o_status.data_clock_en    = (state == ATC_CAL_IDLE) || skip_latched;
    end
endmodule

// file: verilog/atc_config_regs.sv
// write-only trim and extended configuration registers behind an apb slave
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`include "atc_map.svh"
module atc_config_regs
    import atc_pkg::*;
(
    input  wire logic               i_mclk,
    input  wire logic               i_reset,
    input  wire logic               i_psel,
    input  wire logic               i_penable,
    input  wire logic               i_pwrite,
    input  wire logic [7:0]         i_paddr,
    input  wire logic [31:0]        i_pwdata,
    output logic      [31:0]        o_prdata,
    output logic                    o_pready,
    output logic                    o_pslverr,

    input  wire logic               i_cal_request,

    input  wire atc_out_mode_e      i_output_mode,
    input  wire atc_word_s          i_conv_word,
    input  wire logic               i_word_strobe,
    output atc_word_s               o_out_word,

    output logic      [8:0]         o_i_gain_code,
    output logic      [9:0]         o_i_full_scale_mv,
    output logic      [7:0]         o_q_offset_mag,
    output logic                    o_q_offset_neg,
    output logic signed [16:0]      o_q_offset_uv,

    output logic                    o_test_pattern_select,
    output logic                    o_termination_trim_skip,

    output logic                    o_cal_busy,
    output logic                    o_term_trim_active,
    output logic                    o_conv_cal_active,
    output logic                    o_output_data_clock_en
);
    logic [15:0]     i_channel_gain_trim;
    logic [15:0]     extended_configuration;
    logic [15:0]     q_channel_offset_trim;

    logic [2:0]      filler_error;
    logic [7:0]      cal_count;

    logic            cal_req_meta;
    logic            cal_req_sync;
    logic            cal_req_prev;

    logic            sw_cal_start;
    logic            cal_start;
    logic            cal_busy_prev;

    logic            apb_setup;
    logic            apb_access;
    logic            apb_write;
    logic            addr_known;
    logic            addr_writable;

    logic [15:0]     wdata16;
    logic [31:0]     status_word;

    atc_cal_status_s cal_status;
    atc_word_s       pattern_word;

    // true when the filler bits of a written word differ from the fixed values
    function automatic logic filler_bad(input logic [15:0] data,
                                        input logic [15:0] mask,
                                        input logic [15:0] value);
        return ((data & mask) != value);
    endfunction

    // full scale in mV from the 9-bit gain code, linear over the whole code range
    function automatic logic [9:0] gain_to_mv(input logic [8:0] code);
        logic [18:0] scaled;
        scaled = ({10'h000, code} * `ATC_FS_SPAN_MV) / `ATC_GAIN_FULL_CODE;
        return `ATC_FS_MIN_MV + scaled[9:0];
    endfunction

    // signed offset in uV from magnitude and sign
    function automatic logic signed [16:0] offset_to_uv(input logic [7:0] mag,
                                                       input logic       neg);
        logic [23:0] scaled;
        scaled = ({16'h0000, mag} * `ATC_OFS_FULL_UV) / `ATC_OFS_FULL_CODE;
        return neg ? -$signed({1'b0, scaled[15:0]}) : $signed({1'b0, scaled[15:0]});
    endfunction

    // apb decode: zero wait states, so every access completes in its first access cycle
    always_comb
    begin
        apb_setup  = i_psel && !i_penable;
        apb_access = i_psel && i_penable;
        apb_write  = apb_access && i_pwrite;
        wdata16    = i_pwdata[15:0];
    end

    always_comb
    begin
        case (i_paddr)
            `ATC_ADDR_I_GAIN,
            `ATC_ADDR_EXT_CFG,
            `ATC_ADDR_Q_OFFSET,
            `ATC_ADDR_CAL_CMD:
            begin
                addr_known    = 1'b1;
                addr_writable = 1'b1;
            end
            `ATC_ADDR_STATUS:
            begin
                addr_known    = 1'b1;
                addr_writable = 1'b0;
            end
            default:
            begin
                addr_known    = 1'b0;
                addr_writable = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        o_pready  = 1'b1;
        o_pslverr = apb_access &&
                    (!addr_known || (i_pwrite && !addr_writable));
    end

    // gain trim write; gain changes apply directly with no calibration side effect
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            i_channel_gain_trim <= `ATC_RST_I_GAIN;
        end
        else if (apb_write && i_paddr == `ATC_ADDR_I_GAIN)
        begin
            i_channel_gain_trim <= wdata16;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            extended_configuration <= `ATC_RST_EXT_CFG;
        end
        else if (apb_write && i_paddr == `ATC_ADDR_EXT_CFG)
        begin
            extended_configuration <= wdata16;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            q_channel_offset_trim <= `ATC_RST_Q_OFFSET;
        end
        else if (apb_write && i_paddr == `ATC_ADDR_Q_OFFSET)
        begin
            q_channel_offset_trim <= wdata16;
        end
    end

    // filler check is reported, not enforced: the host owns those bits
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            filler_error <= 3'b000;
        end
        else if (apb_write)
        begin
            case (i_paddr)
                `ATC_ADDR_I_GAIN:
                begin
                    filler_error[0] <= filler_bad(wdata16, `ATC_FILL_MASK_I_GAIN, `ATC_FILL_VAL_I_GAIN);
                end
                `ATC_ADDR_EXT_CFG:
                begin
                    filler_error[1] <= filler_bad(wdata16, `ATC_FILL_MASK_EXT_CFG, `ATC_FILL_VAL_EXT_CFG);
                end
                `ATC_ADDR_Q_OFFSET:
                begin
                    filler_error[2] <= filler_bad(wdata16, `ATC_FILL_MASK_Q_OFFSET, `ATC_FILL_VAL_Q_OFFSET);
                end
                default:
                begin
                    filler_error <= filler_error;
                end
            endcase
        end
    end

    // calibration request pin crosses in through two flops
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            cal_req_meta <= 1'b0;
            cal_req_sync <= 1'b0;
            cal_req_prev <= 1'b0;
        end
        else
        begin
            cal_req_meta <= i_cal_request;
            cal_req_sync <= cal_req_meta;
            cal_req_prev <= cal_req_sync;
        end
    end

    // only the pin edge and the command register start calibration, never a trim write
    always_comb
    begin
        sw_cal_start = apb_write && i_paddr == `ATC_ADDR_CAL_CMD && i_pwdata[0];
        cal_start    = (cal_req_sync && !cal_req_prev) || sw_cal_start;
    end

    atc_cal_seq u_cal_seq (
        .i_mclk      (i_mclk),
        .i_reset     (i_reset),
        .i_start     (cal_start),
        .i_trim_skip (o_termination_trim_skip),
        .o_status    (cal_status)
    );

    // completed calibrations, wraps at 255
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            cal_busy_prev <= 1'b0;
            cal_count     <= 8'h00;
        end
        else
        begin
            cal_busy_prev <= cal_status.busy;
            if (cal_busy_prev && !cal_status.busy)
            begin
                cal_count <= cal_count + 8'h01;
            end
        end
    end

    atc_pattern_gen u_pattern_gen (
        .i_mclk    (i_mclk),
        .i_reset   (i_reset),
        .i_enable  (o_test_pattern_select),
        .i_advance (i_word_strobe),
        .i_mode    (i_output_mode),
        .o_word    (pattern_word)
    );

    // output word register: pattern replaces data and over-range together
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_out_word <= '0;
        end
        else if (i_word_strobe)
        begin
            o_out_word <= o_test_pattern_select ? pattern_word : i_conv_word;
        end
    end

    // trim outputs are registered so the analog side never sees decode glitches
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_i_full_scale_mv <= gain_to_mv(`ATC_GAIN_MID);
            o_q_offset_uv     <= 17'sd0;
        end
        else
        begin
            o_i_full_scale_mv <= gain_to_mv(i_channel_gain_trim[`ATC_GAIN_MSB:`ATC_GAIN_LSB]);
            o_q_offset_uv     <= offset_to_uv(q_channel_offset_trim[`ATC_OFS_MSB:`ATC_OFS_LSB],
                                              q_channel_offset_trim[`ATC_OFS_SIGN_BIT]);
        end
    end

    always_comb
    begin
        o_i_gain_code           = i_channel_gain_trim[`ATC_GAIN_MSB:`ATC_GAIN_LSB];
        o_q_offset_mag          = q_channel_offset_trim[`ATC_OFS_MSB:`ATC_OFS_LSB];
        o_q_offset_neg          = q_channel_offset_trim[`ATC_OFS_SIGN_BIT];

        o_test_pattern_select   = extended_configuration[`ATC_EXT_PATTERN_BIT];
        o_termination_trim_skip = extended_configuration[`ATC_EXT_TRIM_SKIP_BIT];

        o_cal_busy              = cal_status.busy;
        o_term_trim_active      = cal_status.term_trim_active;
        o_conv_cal_active       = cal_status.conv_cal_active;
        o_output_data_clock_en  = cal_status.data_clock_en;
    end

    // status: bit 7 flags a gain code outside the recommended window, advisory only
    always_comb
    begin
        status_word        = 32'h0000_0000;

        status_word[0]     = cal_status.busy;
        status_word[1]     = cal_status.term_trim_active;
        status_word[2]     = cal_status.conv_cal_active;
        status_word[3]     = o_test_pattern_select;
        status_word[6:4]   = filler_error;
        status_word[7]     = (o_i_gain_code < `ATC_GAIN_REC_LOW) ||
                             (o_i_gain_code > `ATC_GAIN_REC_HIGH);
        status_word[15:8]  = cal_count;
    end

    // trim registers are write-only and read as zero
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_prdata <= 32'h0000_0000;
        end
        else if (apb_setup && !i_pwrite)
        begin
            o_prdata <= (i_paddr == `ATC_ADDR_STATUS) ?
                        status_word : 32'h0000_0000;
        end
    end
endmodule

// file: verilog/atc_pattern_gen.sv
// test pattern generator feeding the output word path
`timescale 1ns/100ps
module atc_pattern_gen
    import atc_pkg::*;
(
    input  wire logic          i_mclk,
    input  wire logic          i_reset,
    input  wire logic          i_enable,
    input  wire logic          i_advance,
    input  wire atc_out_mode_e i_mode,
    output atc_word_s          o_word
);
    logic [7:0]    count;
    atc_out_mode_e mode_seen;

    // pattern steps once per output word, so it lines up in every output mode
    always_ff @(posedge i_mclk)
    begin
        if (i_reset || !i_enable)
        begin
            count <= 8'h00;
        end
        else if (i_mode != mode_seen)
        begin
            count <= 8'h00;
        end
        else if (i_advance)
        begin
            count <= count + 8'h01;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            mode_seen <= ATC_MODE_SDR;
        end
        else
        begin
            mode_seen <= i_mode;
        end
    end

    // over-range toggles too, so a stuck pin shows in the pattern
    always_comb
    begin
        o_word.i_data     = count;
        o_word.q_data     = ~count;
        o_word.over_range = count[0];
    end
endmodule
